/* rtl/bsl_map.vh */
`ifndef BSL_MAP_VH
`define BSL_MAP_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define BSL_REG_SYSCFG      8'h00
`define BSL_REG_STATUS      8'h04
`define BSL_REG_JUMP        8'h08
`define BSL_REG_BLKCNT      8'h0C
`define BSL_REG_CURADDR     8'h10

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define BSL_CFG_SKIP_BIT    4
`define BSL_CFG_PTYPE_BIT   8
`define BSL_CFG_RST         16'h0000
`define BSL_ST_DONE_BIT     4
`define BSL_ST_LEVEL_BIT    5
`define BSL_ST_SKIP_BIT     6
`define BSL_ST_CMP_BIT      7
`define BSL_ST_ORDER_BIT    8

// ---------------------------------------------------------------
// default flag bit positions inside the block flag word
// ---------------------------------------------------------------
`define BSL_FLG_ZERO        0
`define BSL_FLG_PTYPE       1
`define BSL_FLG_INIT        3
`define BSL_FLG_IGNORE      4
`define BSL_FLG_CMP         13
`define BSL_FLG_LAST        15

// ---------------------------------------------------------------
// header layout and jump targets
// ---------------------------------------------------------------
`define BSL_HDR_LAST        4'h9
`define BSL_HDR_CNT0        4'h4
`define BSL_HDR_FLG0        4'h8
`define BSL_L1_BASE_A       32'hFFA0_0000
`define BSL_L1_BASE_B       32'hFFA0_8000
`define BSL_TWI_BUF_LO      32'hFF90_3F00
`define BSL_TWI_BUF_HI      32'hFF90_3FFF
`define BSL_BMODE_TWI       3'h5

// ---------------------------------------------------------------
// interrupt levels and bus responses
// ---------------------------------------------------------------
`define BSL_LVL_RESET       1'b0
`define BSL_LVL_LOWEST      1'b1
`define BSL_RESP_OKAY       2'h0
`define BSL_RESP_SLVERR     2'h2

`endif

/* rtl/bsl_boot_stream_loader.v */
// Notes on behaviour
// - each block: ten-byte header, body unless zero
// - header bytes 0-3 are destination address
// - header bytes 4-7 are byte count
// - header bytes 8-9 are the flag word
// - zero-fill block has no body in stream
// - zero-fill writes count zero bytes
// - ignored block is skipped, never written
// - compressed flag marks compressed merged block data
// - after last block jump to L1 start
// - processor-type flag picks between two jump targets
// - soft reset with skip bit jumps directly
// - skip bit clear runs full parse
// - drop to lowest level unless variant keeps reset
// - jump in supervisor mode, lowest level unless variant keeps reset
// - init blocks first, executed before other loads
// - after init blocks load until last block
// - twi boot reserves buffer range for last block
`timescale 1ns/10ps
`include "bsl_map.vh"

module bsl_boot_stream_loader #(
  parameter KEEP_RESET_LEVEL = 0,
  parameter FLG_ZERO         = `BSL_FLG_ZERO,
  parameter FLG_PTYPE        = `BSL_FLG_PTYPE,
  parameter FLG_INIT         = `BSL_FLG_INIT,
  parameter FLG_IGNORE       = `BSL_FLG_IGNORE,
  parameter FLG_CMP          = `BSL_FLG_CMP,
  parameter FLG_LAST         = `BSL_FLG_LAST
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        soft_rst_i,
  // boot mode pins
  input  wire [2:0]  bmode_i,
  // boot stream
  input  wire        strm_valid_i,
  input  wire [7:0]  strm_data_i,
  output reg         strm_ready_o,
  // memory write port
  output reg         mem_we_o,
  output reg  [31:0] mem_addr_o,
  output reg  [7:0]  mem_data_o,
  output reg         mem_cmp_o,
  // init block execution
  output reg         init_exec_o,
  output reg  [31:0] init_addr_o,
  input  wire        init_done_i,
  // core hand-off
  output reg         jump_o,
  output reg  [31:0] jump_addr_o,
  output reg         int_level_o,
  output reg         sup_mode_o,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_LEVEL = 4'h1;
  localparam [3:0] S_CHECK = 4'h2;
  localparam [3:0] S_HDR   = 4'h3;
  localparam [3:0] S_DISP  = 4'h4;
  localparam [3:0] S_BODY  = 4'h5;
  localparam [3:0] S_ZERO  = 4'h6;
  localparam [3:0] S_SKIP  = 4'h7;
  localparam [3:0] S_INIT  = 4'h8;
  localparam [3:0] S_WAIT  = 4'h9;
  localparam [3:0] S_END   = 4'hA;
  localparam [3:0] S_JUMP  = 4'hB;
  localparam [3:0] S_DONE  = 4'hC;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [3:0]  hdr_idx;
  reg  [31:0] blk_addr;
  reg  [31:0] blk_cnt;
  reg  [15:0] blk_flg;
  reg  [31:0] cur_addr;
  reg  [31:0] blocks;
  reg  [15:0] syscfg;
  reg         soft_boot;
  reg         done, skipped, cmp_seen, data_seen, order_err;
  reg  [2:0]  bm_s1, bm_s2, bm_s3, bmode;
  wire        take     = strm_valid_i & strm_ready_o;
  wire        cnt_last = (blk_cnt == 32'h0000_0001);
  wire        twi_hole = (bmode == `BSL_BMODE_TWI) & ~blk_flg[FLG_LAST] &
                         (cur_addr >= `BSL_TWI_BUF_LO) & (cur_addr <= `BSL_TWI_BUF_HI);
  wire [31:0] l1_base  = blk_flg[FLG_PTYPE] ? `BSL_L1_BASE_B : `BSL_L1_BASE_A;
  wire [31:0] l1_cfg   = syscfg[`BSL_CFG_PTYPE_BIT] ? `BSL_L1_BASE_B : `BSL_L1_BASE_A;
  wire        skip_now = soft_boot & syscfg[`BSL_CFG_SKIP_BIT];
  wire [3:0]  blk_next = blk_flg[FLG_INIT] ? S_INIT : S_END;

  // ---------------------------------------------------------------
  // boot mode pin synchroniser and reset kind
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      bm_s1 <= 3'h0;
      bm_s2 <= 3'h0;
      bm_s3 <= 3'h0;
      bmode <= 3'h0;
      soft_boot <= 1'b0;
    end else begin
      bm_s1 <= bmode_i;
      bm_s2 <= bm_s1;
      bm_s3 <= bm_s2;
      if (bm_s2 == bm_s3) begin
        bmode <= bm_s3;
      end
      if (soft_rst_i) begin
        soft_boot <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_IDLE:  next_state = S_LEVEL;
      S_LEVEL: next_state = S_CHECK;
      S_CHECK: next_state = skip_now ? S_JUMP : S_HDR;
      S_HDR:   next_state = (take && hdr_idx == `BSL_HDR_LAST) ? S_DISP : S_HDR;
      S_DISP: begin
        if (blk_flg[FLG_IGNORE]) begin
          next_state = (blk_flg[FLG_ZERO] || blk_cnt == 32'h0) ? S_END : S_SKIP;
        end else if (blk_cnt == 32'h0) begin
          next_state = blk_flg[FLG_INIT] ? S_INIT : S_END;
        end else if (blk_flg[FLG_ZERO]) begin
          next_state = S_ZERO;
        end else begin
          next_state = S_BODY;
        end
      end
      S_BODY:  next_state = (take && cnt_last) ? blk_next : S_BODY;
      S_ZERO:  next_state = cnt_last ? blk_next : S_ZERO;
      S_SKIP:  next_state = (take && cnt_last) ? S_END : S_SKIP;
      S_INIT:  next_state = S_WAIT;
      S_WAIT:  next_state = init_done_i ? S_END : S_WAIT;
      S_END:   next_state = blk_flg[FLG_LAST] ? S_JUMP : S_HDR;
      S_JUMP:  next_state = S_DONE;
      S_DONE:  next_state = S_DONE;
      default: next_state = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i || soft_rst_i) begin
      state        <= S_IDLE;
      hdr_idx      <= 4'h0;
      blk_addr     <= 32'h0000_0000;
      blk_cnt      <= 32'h0000_0000;
      blk_flg      <= 16'h0000;
      cur_addr     <= 32'h0000_0000;
      blocks       <= 32'h0000_0000;
      done         <= 1'b0;
      skipped      <= 1'b0;
      cmp_seen     <= 1'b0;
      data_seen    <= 1'b0;
      order_err    <= 1'b0;
      strm_ready_o <= 1'b0;
      mem_we_o     <= 1'b0;
      mem_addr_o   <= 32'h0000_0000;
      mem_data_o   <= 8'h00;
      mem_cmp_o    <= 1'b0;
      init_exec_o  <= 1'b0;
      init_addr_o  <= 32'h0000_0000;
      jump_o       <= 1'b0;
      jump_addr_o  <= 32'h0000_0000;
      int_level_o  <= `BSL_LVL_RESET;
      sup_mode_o   <= 1'b1;
    end else begin
      state        <= next_state;
      strm_ready_o <= (next_state == S_HDR) || (next_state == S_BODY) || (next_state == S_SKIP);
      mem_we_o     <= 1'b0;
      init_exec_o  <= 1'b0;
      jump_o       <= 1'b0;
      case (state)
        S_LEVEL: int_level_o <= KEEP_RESET_LEVEL ? `BSL_LVL_RESET : `BSL_LVL_LOWEST;
        S_HDR: begin
          if (take) begin
            hdr_idx <= hdr_idx + 4'h1;
            if (hdr_idx < `BSL_HDR_CNT0) begin
              blk_addr <= {strm_data_i, blk_addr[31:8]};
            end else if (hdr_idx < `BSL_HDR_FLG0) begin
              blk_cnt <= {strm_data_i, blk_cnt[31:8]};
            end else begin
              blk_flg <= {strm_data_i, blk_flg[15:8]};
            end
          end
        end
        S_DISP: begin
          hdr_idx  <= 4'h0;
          cur_addr <= blk_addr;
          blocks   <= blocks + 32'h0000_0001;
          if (blk_flg[FLG_CMP]) begin
            cmp_seen <= 1'b1;
          end
          if (blk_flg[FLG_INIT] && data_seen) begin
            order_err <= 1'b1;
          end
          if (!blk_flg[FLG_INIT] && !blk_flg[FLG_IGNORE]) begin
            data_seen <= 1'b1;
          end
        end
        S_BODY: begin
          if (take) begin
            mem_we_o   <= ~twi_hole;
            mem_addr_o <= cur_addr;
            mem_data_o <= strm_data_i;
            mem_cmp_o  <= blk_flg[FLG_CMP];
            cur_addr   <= cur_addr + 32'h0000_0001;
            blk_cnt    <= blk_cnt - 32'h0000_0001;
          end
        end
        S_ZERO: begin
          mem_we_o   <= ~twi_hole;
          mem_addr_o <= cur_addr;
          mem_data_o <= 8'h00;
          mem_cmp_o  <= 1'b0;
          cur_addr   <= cur_addr + 32'h0000_0001;
          blk_cnt    <= blk_cnt - 32'h0000_0001;
        end
        S_SKIP: begin
          if (take) begin
            blk_cnt <= blk_cnt - 32'h0000_0001;
          end
        end
        S_INIT: begin
          init_exec_o <= 1'b1;
          init_addr_o <= blk_addr;
        end
        S_JUMP: begin
          jump_o      <= 1'b1;
          jump_addr_o <= skipped ? l1_cfg : l1_base;
          sup_mode_o  <= 1'b1;
          done        <= 1'b1;
        end
        S_CHECK: skipped <= skip_now;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  reg         aw_held, w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        wr_go   = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BSL_RESP_OKAY;
      syscfg        <= `BSL_CFG_RST;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `BSL_REG_SYSCFG) begin
          s_axi_bresp <= `BSL_RESP_OKAY;
          if (w_strb[0]) begin
            syscfg[7:0] <= w_data[7:0];
          end
          if (w_strb[1]) begin
            syscfg[15:8] <= w_data[15:8];
          end
        end else if (aw_addr == `BSL_REG_STATUS || aw_addr == `BSL_REG_JUMP ||
                     aw_addr == `BSL_REG_BLKCNT || aw_addr == `BSL_REG_CURADDR) begin
          s_axi_bresp <= `BSL_RESP_OKAY;
        end else begin
          s_axi_bresp <= `BSL_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BSL_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `BSL_RESP_OKAY;
        case (s_axi_araddr)
          `BSL_REG_SYSCFG:  s_axi_rdata <= {16'h0000, syscfg};
          `BSL_REG_STATUS:  s_axi_rdata <= {23'h00_0000, order_err, cmp_seen, skipped,
                                            int_level_o, done, state};
          `BSL_REG_JUMP:    s_axi_rdata <= jump_addr_o;
          `BSL_REG_BLKCNT:  s_axi_rdata <= blocks;
          `BSL_REG_CURADDR: s_axi_rdata <= cur_addr;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BSL_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* dv/bsl_loader_properties.sv */
`timescale 1ns/10ps
`include "bsl_map.vh"
module bsl_loader_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // stream and memory
  input wire logic        strm_valid_i,
  input wire logic        strm_ready_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  // core hand-off
  input wire logic        jump_o,
  input wire logic [31:0] jump_addr_o,
  input wire logic        int_level_o,
  input wire logic        sup_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_jump;
    jump_o;
  endsequence
  sequence s_burst;
    mem_we_o ##1 mem_we_o;
  endsequence
  chk_sup_mode: assert property (sup_mode_o)
    else $error("core not in supervisor mode");
  chk_jump_level: assert property (s_jump |-> int_level_o && sup_mode_o)
    else $error("jump taken at wrong level");
  chk_jump_target: assert property (s_jump |-> jump_addr_o == `BSL_L1_BASE_A ||
    jump_addr_o == `BSL_L1_BASE_B)
    else $error("jump target not an L1 start");
  chk_jump_stops: assert property (s_jump |=> (!jump_o && !strm_ready_o) [*8])
    else $error("parsing continued after jump");
  chk_addr_incr: assert property (s_burst |->
    mem_addr_o == $past(mem_addr_o) + 32'h0000_0001)
    else $error("write address did not increment");
  chk_level_first: assert property ($rose(strm_ready_o) |-> int_level_o)
    else $error("stream accepted at reset level");
  chk_parse_start: assert property ($fell(sys_rst_i) |-> ##[1:4] strm_ready_o)
    else $error("parsing did not start after reset");
  chk_write_level: assert property (mem_we_o |-> int_level_o && !jump_o)
    else $error("memory written outside parsing");
endmodule
bind bsl_boot_stream_loader bsl_loader_checker chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .strm_valid_i(strm_valid_i), .strm_ready_o(strm_ready_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .jump_o(jump_o), .jump_addr_o(jump_addr_o),
  .int_level_o(int_level_o), .sup_mode_o(sup_mode_o));

/* dv/bsl_stream_src.sv */
`timescale 1ns/10ps
module bsl_stream_src (
  // clock and pacing
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  // stream
  input  wire logic       strm_ready_i,
  output reg              strm_valid_o,
  output reg        [7:0] strm_data_o
);
  logic [7:0] q[$];
  logic       taken;
  initial begin
    strm_valid_o = 1'b0;
    strm_data_o  = 8'h00;
  end
  // bytes leave in queue order, held until taken
  always @(posedge clk_i) begin
    taken = strm_valid_o && strm_ready_i;
    if (taken) void'(q.pop_front());
    if (q.size() > 0 && !(slow_i && taken)) begin
      strm_valid_o <= 1'b1;
      strm_data_o  <= q[0];
    end else begin
      strm_valid_o <= 1'b0;
      strm_data_o  <= ~strm_data_o;
    end
  end
endmodule

/* dv/bsl_boot_stream_loader_tb_top.sv */
`timescale 1ns/10ps
`include "bsl_map.vh"
module bsl_boot_stream_loader_tb_top;
  localparam [15:0] F_ZERO = 16'h0001 << `BSL_FLG_ZERO;
  localparam [15:0] F_PTYP = 16'h0001 << `BSL_FLG_PTYPE;
  localparam [15:0] F_INIT = 16'h0001 << `BSL_FLG_INIT;
  localparam [15:0] F_IGN  = 16'h0001 << `BSL_FLG_IGNORE;
  localparam [15:0] F_CMP  = 16'h0001 << `BSL_FLG_CMP;
  localparam [15:0] F_LAST = 16'h0001 << `BSL_FLG_LAST;
  reg         clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0, init_done_i = 1'b0, slow = 1'b0;
  reg  [2:0]  bmode_i = 3'h1;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0000_0000, rd_d, last_jump;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [1:0]  rd_r, wr_r;
  reg         last_lvl;
  wire        s_valid, s_ready, we, cmp, iexec, jump, lvl, sup, awready, wready, bvalid;
  wire        arready, rvalid;
  wire [7:0]  s_data, m_data;
  wire [31:0] m_addr, iaddr, jaddr, rdata;
  wire [1:0]  bresp, rresp;
  integer     fail_count = 0, samples_checked = 0, wr_count, jumps, init_at, cmp_count;
  reg  [7:0]  mem [logic [31:0]];

  always #2.5 clk_i = ~clk_i;

  bsl_boot_stream_loader dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
    .bmode_i(bmode_i), .strm_valid_i(s_valid), .strm_data_i(s_data), .strm_ready_o(s_ready),
    .mem_we_o(we), .mem_addr_o(m_addr), .mem_data_o(m_data), .mem_cmp_o(cmp),
    .init_exec_o(iexec), .init_addr_o(iaddr), .init_done_i(init_done_i), .jump_o(jump),
    .jump_addr_o(jaddr), .int_level_o(lvl), .sup_mode_o(sup), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  bsl_stream_src src_u (.clk_i(clk_i), .slow_i(slow), .strm_ready_i(s_ready),
    .strm_valid_o(s_valid), .strm_data_o(s_data));

  // ------------------------------------------------------------
  // monitors and core model
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    init_done_i <= iexec;
    if (we) begin
      mem[m_addr] = m_data;
      wr_count = wr_count + 1;
      if (cmp) cmp_count = cmp_count + 1;
    end
    if (iexec) init_at = wr_count;
    if (jump) begin
      jumps = jumps + 1;
      last_jump = jaddr;
      last_lvl = lvl;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task do_reset;
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    mem.delete();
    wr_count = 0;
    jumps = 0;
    init_at = -1;
    cmp_count = 0;
  endtask
  function [7:0] pat(input [31:0] a, input integer i);
    pat = a[7:0] + i[7:0] + 8'h11;
  endfunction
  task blk(input [31:0] a, input [31:0] n, input [15:0] f);
    integer i;
    for (i = 0; i < 4; i++) src_u.q.push_back(a[8*i+:8]);
    for (i = 0; i < 4; i++) src_u.q.push_back(n[8*i+:8]);
    for (i = 0; i < 2; i++) src_u.q.push_back(f[8*i+:8]);
    if (!f[`BSL_FLG_ZERO]) for (i = 0; i < n; i++) src_u.q.push_back(pat(a, i));
  endtask
  task region(input [31:0] a, input integer n, input integer kind);
    integer i;
    for (i = 0; i < n; i++)
      if (kind == 2) chk("absent", mem.exists(a + i), 0);
      else chk("mem", mem[a + i], kind ? 8'h00 : pat(a, i));
  endtask
  task wait_jump(input integer n);
    integer k;
    k = 0;
    while (jumps < n && k < 5000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (10) @(posedge clk_i);
  endtask
  task soft_pulse;
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
  endtask
  task axi_wr(input [7:0] a, input [31:0] d);
    integer k;
    @(posedge clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; k = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 100);
    wr_r = bresp;
    bready <= 1'b0;
  endtask
  task axi_rd(input [7:0] a);
    integer k;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; k = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 100);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task test_full_boot;
    do_reset;
    blk(32'hFF80_0000, 2, F_INIT);
    blk(32'hFF80_0100, 5, F_CMP);
    blk(32'hFF80_0200, 4, F_ZERO);
    blk(32'hFF80_0300, 3, F_IGN);
    blk(32'hFF80_0400, 0, 16'h0000);
    blk(32'hFFA0_8000, 2, F_LAST | F_PTYP);
    repeat (40) @(posedge clk_i);
    slow <= 1'b1;
    wait_jump(1);
    slow <= 1'b0;
    chk("jumps", jumps, 1);
    chk("jump_addr", last_jump, `BSL_L1_BASE_B);
    chk("jump_level", last_lvl, 1);
    chk("init_order", init_at, 2);
    chk("init_addr", iaddr, 32'hFF80_0000);
    chk("writes", wr_count, 13);
    chk("cmp_bytes", cmp_count, 5);
    chk("left", src_u.q.size(), 0);
    region(32'hFF80_0000, 2, 0);
    region(32'hFF80_0100, 5, 0);
    region(32'hFF80_0200, 4, 1);
    region(32'hFF80_0300, 3, 2);
    region(32'hFFA0_8000, 2, 0);
  endtask
  task test_twi_boot;
    bmode_i <= `BSL_BMODE_TWI;
    do_reset;
    blk(`BSL_TWI_BUF_LO, 2, 16'h0000);
    blk(32'hFF90_3E00, 1, 16'h0000);
    blk(`BSL_TWI_BUF_HI - 32'h0000_0001, 2, F_LAST);
    wait_jump(1);
    chk("jump_addr", last_jump, `BSL_L1_BASE_A);
    region(`BSL_TWI_BUF_LO, 2, 2);
    region(32'hFF90_3E00, 1, 0);
    region(`BSL_TWI_BUF_HI - 32'h0000_0001, 2, 0);
    bmode_i <= 3'h1;
  endtask
  task test_skip_boot;
    do_reset;
    axi_wr(`BSL_REG_SYSCFG, 32'h0000_0110);
    chk("wr_resp", wr_r, `BSL_RESP_OKAY);
    axi_rd(`BSL_REG_SYSCFG);
    chk("syscfg", rd_d, 32'h0000_0110);
    axi_rd(8'h40);
    chk("unmapped_resp", rd_r, `BSL_RESP_SLVERR);
    chk("unmapped_data", rd_d, 32'h0000_0000);
    axi_wr(8'h40, 32'h0000_0000);
    chk("wr_unmapped", wr_r, `BSL_RESP_SLVERR);
    soft_pulse;
    wait_jump(1);
    chk("skip_jump", last_jump, `BSL_L1_BASE_B);
    axi_rd(`BSL_REG_JUMP);
    chk("jump_reg", rd_d, `BSL_L1_BASE_B);
    axi_wr(`BSL_REG_SYSCFG, 32'h0000_0010);
    soft_pulse;
    wait_jump(2);
    chk("skip_jump", last_jump, `BSL_L1_BASE_A);
    chk("skip_writes", wr_count, 0);
    axi_wr(`BSL_REG_SYSCFG, 32'h0000_0000);
    soft_pulse;
    repeat (8) @(posedge clk_i);
    chk("parse_ready", s_ready, 1);
    chk("no_jump", jumps, 2);
  endtask

  initial begin
    #100_000;
    fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    test_full_boot;
    test_twi_boot;
    test_skip_boot;
    stop_test;
  end
endmodule
